// File: prr_ctl.sv
// Controller model: shared address, row and column strobes, free-running converter clock, column clock gated by col_run.
// Assumes the bench calls its tasks; every pin moves 1 ns after a clock rise.
`timescale 1ns/1ps
module prr_ctl
  import prr_pkg::*;
(
  // Bench clock.
  input wire logic clock,
  // Pins towards the sensor.
  output logic [ADDR_W-1:0] address,
  output logic row_address_load,
  output logic column_address_load,
  output logic signal_sample,
  output logic row_reset,
  output logic reset_sample,
  output logic reference_level_row_reset,
  output logic column_clock,
  output logic converter_clock
);
  logic col_run = 1'b1;
  int div = 0;
  // No pin of this block takes the calibration pulse; the model still keeps its timing.
  logic calibration = 1'b0;
  bit cal_done = 1'b0;
  // Dual slope is not used, so the reference reset never leaves low.
  initial {address, row_address_load, column_address_load, signal_sample, row_reset,
    reset_sample, reference_level_row_reset, column_clock, converter_clock} = '0;
  // The column clock runs while col_run is set, since an idle column register leaks; halted, it rests low.
  always @(posedge clock) begin
    #1;
    div = (div + 1) % 5;
    if (div == 0) begin
      column_clock = col_run & ~column_clock;
      converter_clock = ~converter_clock;
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // A strobe high for hi cycles, then low for lo cycles.
  task automatic pulse(ref logic s, input int hi, input int lo);
    s = 1'b1;
    tk(hi);
    s = 1'b0;
    tk(lo);
  endtask
  // Row select and sampling at the minimum spacings, 100 ns a cycle.
  task automatic row_seq(input logic [ADDR_W-1:0] row, input logic [ADDR_W-1:0] nxt);
    address = row;
    tk(2);
    pulse(row_address_load, 2, 3);
    address = nxt;
    tk(29);
    // Calibration starts 200 ns into the sample pulse, once per frame, 200 ns wide.
    signal_sample = 1'b1;
    tk(2);
    calibration = ~cal_done;
    tk(2);
    signal_sample = 1'b0;
    calibration = 1'b0;
    cal_done = 1'b1;
    tk(1);
    pulse(row_reset, 2, 12);
    pulse(reset_sample, 4, 0);
  endtask
  // Loading just after a column clock rise keeps that rise out of the count.
  task automatic col_load(input logic [ADDR_W-1:0] col);
    @(posedge column_clock);
    tk(1);
    address = col;
    tk(2);
    pulse(column_address_load, 2, 3);
  endtask
endmodule

// File: prr_pkg.sv
// Package for the pixel row/column readout digital model.
// Assumes a single 10 MHz clock; all sensor control pins except reference_level_row_reset are sampled in this domain.
package prr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 10;
  localparam int CLK_NS = 100;
  // Converter output delay after the falling conversion edge.
  localparam int ADC_VALID_NS = 20;
  localparam int ADC_VALID_CYC = (ADC_VALID_NS + CLK_NS - 1) / CLK_NS;
  // Column pipeline depth: first pixel valid at the third column clock rise.
  localparam int PIPE_DEPTH = 3;
  // Column clock idle time treated as unsafe, in microseconds.
  localparam int IDLE_US = 100;
  localparam int IDLE_CYC = IDLE_US * 1000 / CLK_NS;
  // Row sampling sequence states.
  typedef enum logic [1:0] {
    prr_idle,
    prr_sig,
    prr_rst,
    prr_ref
  } prr_samp_e;
endpackage

// File: prr_readout.sv
// Digital control side of a directly addressed pixel array readout.
// Assumes all strobes come from an external controller, asynchronous to clock.
// How it works
// [R1] Row strobe latches address, selects row.
// [R2] Controller may change address after row latch.
// [R3] Controller waits 3.6 us before sample fall.
// [R4] Sample pulses each last 0.4 us.
// [R5] Reset rises no earlier than sample fall.
// [R6] Reset pulse held at least 200 ns.
// [R7] Reference sample falls 1.6 us after reset.
// [R8] Reset rises no earlier than row strobe fall.
// [R9] Sample, reset, reference order captures both levels.
// [R10] After sampling, readout starts; other rows resettable.
// [R11] Calibration starts 100-200 ns after sample rise.
// [R12] Calibration once per frame, at least 100 ns.
// [R13] Column strobe rising edge latches column address.
// [R14] Column clock loads selection, drives subtraction.
// [R15] First pixel valid at third column clock.
// [R16] Converter result valid 20 ns after falling edge; the model presents it one clock after the synchronised fall.
// [R17] Controller keeps column clock running always; the model stops it while col_run is low.
// [R18] Idle column clock is flagged unsafe.
// [R19] Converter outputs disableable; converter can power down.
// [R20] Colour variant: pixel (0,0) is red.
// [R21] Converter bit 0 lowest, bit 9 highest.
// [R22] Reference reset unused without dual slope.
// [R23] Integration time runs from reset to selection.
// [R24] Controller walks rows then columns in window.
`timescale 1ns/1ps
module prr_readout
  import prr_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Shared address and strobes from the controller.
  input wire logic [ADDR_W-1:0] address,
  input wire logic row_address_load,
  input wire logic column_address_load,
  input wire logic signal_sample,
  input wire logic row_reset,
  input wire logic reset_sample,
  input wire logic reference_level_row_reset,
  input wire logic column_clock,
  input wire logic converter_clock,
  input wire logic converter_output_enable_n,
  input wire logic converter_power_down,
  // Digitised pixel sample from the analog path.
  input wire logic [DATA_W-1:0] pixel_level,
  // Row and column state.
  output logic [ADDR_W-1:0] selected_row,
  output logic [ADDR_W-1:0] reset_row,
  output logic [ADDR_W-1:0] column_address,
  output logic [ADDR_W-1:0] selected_column,
  output logic row_sampled,
  output logic pixel_valid,
  output logic pixel_red,
  output logic column_clock_unsafe,
  // Converter data pins, bit 0 lowest.
  output logic [DATA_W-1:0] converter_data,
  output logic [DATA_W-1:0] converter_data_oe_n
);
  // Two-flop synchronisers for every pin input except reference_level_row_reset, which is not used.
  localparam int NS = 9;
  logic [NS-1:0] s1, s2, s3;
  logic [ADDR_W-1:0] a1, a2;
  logic [DATA_W-1:0] p1, p2;
  wire [NS-1:0] pins = {row_address_load, column_address_load, signal_sample, row_reset,
    reset_sample, column_clock, converter_clock, converter_output_enable_n,
    converter_power_down};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      a1 <= '0;
      a2 <= '0;
      p1 <= '0;
      p2 <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      a1 <= address;
      a2 <= a1;
      p1 <= pixel_level;
      p2 <= p1;
    end
  end

  // Edge decode on the synchronised copies; s3 is only the delayed second stage.
  function automatic logic rise(input logic now, input logic old);
    return now & ~old;
  endfunction
  wire row_ld_rise = rise(s2[8], s3[8]);
  wire col_ld_rise = rise(s2[7], s3[7]);
  wire sig_fall = rise(s3[6], s2[6]);
  wire rst_rise = rise(s2[5], s3[5]);
  wire rst_fall = rise(s3[5], s2[5]);
  wire ref_fall = rise(s3[4], s2[4]);
  wire colclk_rise = rise(s2[3], s3[3]);
  wire adc_fall = rise(s3[2], s2[2]);
  wire adc_oe_n = s2[1];
  wire adc_pd = s2[0];

  // Row sampling sequence: signal sample, row reset, reference sample.
  prr_samp_e state;
  prr_samp_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      prr_idle: if (row_ld_rise) next_state = prr_sig;
      prr_sig: if (sig_fall) next_state = prr_rst; // [R9]
      prr_rst: if (rst_fall) next_state = prr_ref;
      prr_ref: if (ref_fall) next_state = prr_idle;
    endcase
    if (row_ld_rise) next_state = prr_sig;
  end
  wire seq_done = (state == prr_ref) && ref_fall;

  // Row address and reset-row capture; a reset names whatever address is present.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= prr_idle;
      selected_row <= '0;
      reset_row <= '0;
      row_sampled <= 1'b0;
    end else begin
      state <= next_state;
      if (row_ld_rise) selected_row <= a2; // [R1] [R23]
      if (rst_rise) reset_row <= a2;
      if (row_ld_rise) row_sampled <= 1'b0;
      else if (seq_done) row_sampled <= 1'b1; // [R9] [R10]
    end
  end

  // Column latch, selection register and three-stage output pipeline.
  logic [PIPE_DEPTH-1:0] pipe;
  logic [ADDR_W-1:0] col_pend;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      column_address <= '0;
      selected_column <= '0;
      pipe <= '0;
      pixel_valid <= 1'b0;
      pixel_red <= 1'b0;
    end else begin
      if (col_ld_rise) column_address <= a2; // [R13]
      if (colclk_rise) begin
        selected_column <= column_address; // [R14]
        pipe <= {pipe[PIPE_DEPTH-2:0], 1'b1};
        pixel_valid <= pipe[PIPE_DEPTH-2]; // [R15]
        // Colour follows the column being loaded, so it always matches selected_column.
        pixel_red <= ~selected_row[0] & ~col_pend[0]; // [R20]
      end
      // A new column address restarts the pipeline, so valid drops until it refills.
      if (col_ld_rise) begin
        pipe <= '0;
        pixel_valid <= 1'b0; // [R15]
      end
    end
  end
  assign col_pend = column_address;

  // Idle watchdog on the column clock; counter saturates at its limit.
  logic [$clog2(IDLE_LIMIT+1)-1:0] idle_cnt;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= '0;
      column_clock_unsafe <= 1'b0;
    end else begin
      if (colclk_rise) idle_cnt <= '0;
      else if (idle_cnt != IDLE_LIMIT[$bits(idle_cnt)-1:0]) idle_cnt <= idle_cnt + 1'b1;
      column_clock_unsafe <= (idle_cnt == IDLE_LIMIT[$bits(idle_cnt)-1:0]); // [R18]
    end
  end

  // Converter: sample on the falling clock edge, present one cycle later
  // (rounded up from 20 ns). Output enables drop while driving.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      converter_data <= '0;
      converter_data_oe_n <= '1;
    end else begin
      if (adc_fall && !adc_pd) converter_data <= p2; // [R16] [R21]
      converter_data_oe_n <= {DATA_W{adc_oe_n | adc_pd}}; // [R19]
    end
  end

  // Rises seen since the last column load, counted apart from the pipeline it checks.
  logic [1:0] rise_seen;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rise_seen <= 2'h0;
    end else if (col_ld_rise) begin
      rise_seen <= 2'h0;
    end else if (colclk_rise && rise_seen != 2'h3) begin
      rise_seen <= rise_seen + 2'h1;
    end
  end

  // Checks on the device's own behaviour.
  property p_row_latch;
    @(posedge clock) disable iff (!nrst)
      row_ld_rise |=> selected_row == $past(a2);
  endproperty
  a_row_latch: assert property (p_row_latch) else $error("row not latched"); // [R1]
  property p_col_latch;
    @(posedge clock) disable iff (!nrst)
      col_ld_rise |=> column_address == $past(a2);
  endproperty
  a_col_latch: assert property (p_col_latch) else $error("column not latched"); // [R13]
  property p_col_sel;
    @(posedge clock) disable iff (!nrst)
      colclk_rise |=> selected_column == $past(col_pend);
  endproperty
  a_col_sel: assert property (p_col_sel) else $error("column select missed"); // [R14]
  property p_pipe;
    @(posedge clock) disable iff (!nrst)
      col_ld_rise |=> !pixel_valid;
  endproperty
  a_pipe: assert property (p_pipe) else $error("pixel valid kept after column load"); // [R15]
  property p_valid_count;
    @(posedge clock) disable iff (!nrst)
      pixel_valid == (rise_seen == 2'h3);
  endproperty
  a_valid_count: assert property (p_valid_count) else $error("pixel valid off third rise"); // [R15]
  property p_valid_third;
    @(posedge clock) disable iff (!nrst)
      $rose(pixel_valid) |-> $past(pipe[1]) && $past(colclk_rise);
  endproperty
  a_valid_third: assert property (p_valid_third) else $error("pixel valid early"); // [R15]
  property p_seq;
    @(posedge clock) disable iff (!nrst)
      $rose(row_sampled) |-> $past(state) == prr_ref;
  endproperty
  a_seq: assert property (p_seq) else $error("row sampled out of order"); // [R9]
  property p_adc;
    @(posedge clock) disable iff (!nrst)
      (adc_fall && !adc_pd) |=> converter_data == $past(p2);
  endproperty
  a_adc: assert property (p_adc) else $error("converter result missing"); // [R16]
  property p_oe;
    @(posedge clock) disable iff (!nrst)
      adc_pd |=> converter_data_oe_n == '1;
  endproperty
  a_oe: assert property (p_oe) else $error("pins driven in power down"); // [R19]
  property p_idle;
    @(posedge clock) disable iff (!nrst)
      colclk_rise |=> ##1 !column_clock_unsafe;
  endproperty
  a_idle: assert property (p_idle) else $error("unsafe flag after clock"); // [R18]
  property p_red;
    @(posedge clock) disable iff (!nrst)
      colclk_rise |=> pixel_red == (!$past(selected_row[0]) && !$past(col_pend[0]));
  endproperty
  a_red: assert property (p_red) else $error("origin pixel not red"); // [R20]
endmodule

// File: testbench.sv
// Bench: resets the readout, walks rows and columns through the controller model.
// Assumes the controller model drives every strobe and the converter clock; the bench drives the converter enable and power-down pins.
`timescale 1ns/1ps
module testbench;
  import prr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic converter_output_enable_n = 1'b0;
  logic converter_power_down = 1'b0;
  logic [DATA_W-1:0] pixel_level = '0;
  wire [ADDR_W-1:0] address;
  wire row_address_load, column_address_load, signal_sample, row_reset, reset_sample;
  wire reference_level_row_reset, column_clock, converter_clock;
  logic [ADDR_W-1:0] selected_row, reset_row, column_address, selected_column, row, col;
  logic row_sampled, pixel_valid, pixel_red, column_clock_unsafe;
  logic [DATA_W-1:0] converter_data, converter_data_oe_n, held;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  // A short idle limit keeps the unsafe-clock test brief.
  prr_readout #(.IDLE_LIMIT(20)) prr_readout_i (.*);
  prr_ctl prr_ctl_i (.*);
  always #50 clock = ~clock;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The tests need under 1000 cycles, so a hang is cut at 3000.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end
  // Reset, then each even/odd corner of the mosaic, rows before columns.
  initial begin
    void'($urandom(72));
    tick(4);
    chk(converter_data_oe_n, 10'h3FF);
    nrst = 1'b1;
    tick(4);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      row = (10'($urandom) & 10'h3FE) | 10'(k & 1);
      col = (10'($urandom) & 10'h3FE) | 10'(k >> 1);
      prr_ctl_i.row_seq(row, ~row);
      tick(6);
      chk(selected_row, row);
      chk(10'(row_sampled), 10'h001);
      chk(reset_row, ~row);
      prr_ctl_i.col_load(col);
      chk(column_address, col);
      chk(10'(pixel_valid), 10'h000);
      @(posedge column_clock);
      tick(5);
      chk(selected_column, col);
      chk(10'(pixel_red), 10'(row % 2 == 0 && col % 2 == 0));
      repeat (2) begin
        chk(10'(pixel_valid), 10'h000);
        @(posedge column_clock);
        tick(5);
      end
      chk(10'(pixel_valid), 10'h001);
    end
    $display("test rows and columns done");
    // Power-down must freeze the result and release the pins.
    pixel_level = 10'($urandom);
    held = pixel_level;
    tick(3);
    @(negedge converter_clock);
    tick(5);
    chk(converter_data, held);
    chk(converter_data_oe_n, 10'h000);
    converter_power_down = 1'b1;
    pixel_level = ~held;
    tick(3);
    @(negedge converter_clock);
    tick(5);
    chk(converter_data, held);
    chk(converter_data_oe_n, 10'h3FF);
    converter_power_down = 1'b0;
    converter_output_enable_n = 1'b1;
    tick(4);
    chk(converter_data_oe_n, 10'h3FF);
    // Leaving power down, the next falling edge converts the new level again.
    converter_output_enable_n = 1'b0;
    @(negedge converter_clock);
    tick(5);
    chk(converter_data, ~held);
    chk(converter_data_oe_n, 10'h000);
    $display("test converter done");
    chk(10'(column_clock_unsafe), 10'h000);
    prr_ctl_i.col_run = 1'b0;
    tick(30);
    chk(10'(column_clock_unsafe), 10'h001);
    prr_ctl_i.col_run = 1'b1;
    tick(15);
    chk(10'(column_clock_unsafe), 10'h000);
    $display("test idle done");
    stop_test();
  end
endmodule
